// >>> design/mbc_pkg.sv
// Package: register map, reset values and timing constants for mbc block
package mbc_pkg;
  // Register offsets
  localparam logic [7:0] MBC_MODE_OFS = 8'h1F; // Mode and output select
  localparam logic [7:0] MBC_WDOG_OFS = 8'h20; // Control channel watchdog
  localparam logic [7:0] MBC_I2C_OFS = 8'h21; // I2C forwarding control
  // Field positions in mode_and_output_select
  localparam int MBC_OVR_OUT_BIT = 7; // Output control override
  localparam int MBC_OUT_EN_BIT = 6; // Output enable setting
  localparam int MBC_OSS_BIT = 5; // Output sleep state setting
  localparam int MBC_OVR_MODE_BIT = 4; // Mode override
  localparam int MBC_PIN12_BIT = 3; // Pin status, 12-bit HF
  localparam int MBC_PIN10_BIT = 2; // Pin status, 10-bit
  localparam int MBC_MODE12_BIT = 1; // 12-bit high frequency mode
  localparam int MBC_MODE10_BIT = 0; // 10-bit mode
  // Field positions in watchdog and I2C registers
  localparam int MBC_WDOG_TO_MSB = 7; // Timeout field top
  localparam int MBC_WDOG_TO_LSB = 1; // Timeout field bottom
  localparam int MBC_WDOG_DIS_BIT = 0; // Watchdog disable
  localparam int MBC_PASS_ALL_BIT = 7; // Pass-through all
  localparam int MBC_HOLD_MSB = 6; // SDA hold field top
  localparam int MBC_HOLD_LSB = 4; // SDA hold field bottom
  localparam int MBC_FILT_MSB = 3; // Filter depth top
  localparam int MBC_FILT_LSB = 0; // Filter depth bottom
  // Reset values
  localparam logic [7:0] MBC_MODE_RST = 8'h00; // Mode register
  localparam logic [6:0] MBC_WDOG_TO_RST = 7'h7F; // Timeout all ones
  localparam logic MBC_WDOG_DIS_RST = 1'h0; // Watchdog on
  localparam logic MBC_PASS_ALL_RST = 1'h0; // Matching only
  localparam logic [2:0] MBC_HOLD_RST = 3'h1; // 50 ns hold
  localparam logic [3:0] MBC_FILT_RST = 4'h7; // 70 ns filter
  // Timing
  localparam int MBC_CLK_PERIOD_NS = 40; // 25 MHz clock
  localparam int MBC_WDOG_UNIT_NS = 2000000; // 2 ms per step
  localparam int MBC_WDOG_UNIT_CYCLES = MBC_WDOG_UNIT_NS / MBC_CLK_PERIOD_NS;
  localparam int MBC_HOLD_UNIT_NS = 50; // Hold step
  localparam int MBC_FILT_UNIT_NS = 10; // Filter step
  localparam int MBC_WDOG_CNT_W = 16; // Unit counter width
endpackage

// >>> design/mbc_glitch_filter.sv
// Glitch filter: passes a level only once it outlasts a programmed width
`timescale 1ns/100ps
module mbc_glitch_filter (
  input wire logic ref_clk, // 25 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic din, // Synchronised input level
  input wire logic [2:0] limit, // Cycles a pulse must exceed
  output logic dout // Filtered level
);
  logic [2:0] cnt; // Cycles the input has differed
  logic [2:0] next_cnt;
  logic next_dout;

  // Count how long input differs; adopt it after limit cycles
  always_comb begin
    next_cnt = 3'h0;
    next_dout = dout;
    if (din != dout) begin
      if (cnt >= limit) begin
        next_dout = din;
      end else begin
        next_cnt = cnt + 3'h1;
      end
    end
  end

  // Register state; idle high like an I2C line
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt <= 3'h0;
      dout <= 1'h1;
    end else begin
      cnt <= next_cnt;
      dout <= next_dout;
    end
  end
endmodule

// >>> design/mbc_config_regs.sv
// Mode, output override, watchdog and I2C forwarding configuration
// Overview of operation
// RQ1 - Override bit 7 selects register over pins
// RQ2 - Bit 6 gives overridden output enable
// RQ3 - Bit 5 gives overridden sleep state
// RQ4 - Mode override ignores forward channel mode bits
// RQ5 - Bits 3:2 show sampled mode pin, read-only
// RQ6 - Bit 1 selects 12-bit HF, auto-updated
// RQ7 - Both mode bits zero means 12-bit LF
// RQ8 - Bit 0 enables 10-bit mode, auto-updated
// RQ9 - Watchdog ends transactions after field times 2ms
// RQ10 - Software must not program timeout zero
// RQ11 - Disable bit stops the watchdog
// RQ12 - Pass-all forwards foreign addresses, remapped
// RQ13 - Otherwise forward only matching remote addresses
// RQ14 - SDA hold equals field times 50ns
// RQ15 - Reject glitches up to field times 10ns
`timescale 1ns/100ps
module mbc_config_regs #(
  parameter int WDOG_UNIT_CYCLES = mbc_pkg::MBC_WDOG_UNIT_CYCLES // 2 ms
) (
  input wire logic ref_clk, // 25 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic reg_wr, // Register write strobe
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, one cycle after address
  input wire logic output_enable_pin, // Output enable pin
  input wire logic oss_pin, // Output sleep state pin
  input wire logic mode_pin_12hf, // Mode pin decodes 12-bit HF
  input wire logic mode_pin_10, // Mode pin decodes 10-bit
  input wire logic fwd_mode_valid, // Forward channel mode update
  input wire logic fwd_mode_12hf, // Forward channel 12-bit HF
  input wire logic fwd_mode_10, // Forward channel 10-bit
  output logic output_enable, // Effective output enable
  output logic output_sleep_state, // Effective sleep state select
  output logic mode_12hf, // 12-bit high frequency active
  output logic mode_10, // 10-bit active
  input wire logic ctrl_chan_busy, // Control channel busy
  output logic ctrl_chan_abort, // One-cycle abort pulse
  input wire logic i2c_addr_valid, // Incoming I2C address pulse
  input wire logic [6:0] i2c_addr, // Incoming I2C address
  input wire logic [6:0] own_id, // Own I2C address
  input wire logic [6:0] remote_serializer_target, // Target at 0x06
  input wire logic [6:0] remote_alias_id, // Configured remote address
  output logic fwd_req, // Forward access pulse
  output logic [6:0] fwd_addr, // Address sent over the channel
  input wire logic scl_pin, // Raw SCL level
  input wire logic sda_pin, // Raw SDA level
  output logic scl_clean, // Filtered SCL
  output logic sda_clean // Filtered and held SDA
);
  import mbc_pkg::*;

  logic [7:0] mode_reg; // mode_and_output_select, bits 3:2 unused
  logic [7:0] next_mode_reg;
  logic [6:0] wdog_to; // Timeout in 2 ms steps
  logic wdog_dis; // Watchdog disable
  logic [7:0] i2c_reg; // i2c_forwarding_control
  logic [7:0] next_i2c_reg;
  logic [6:0] next_wdog_to;
  logic next_wdog_dis;
  logic [5:0] meta, sync, sync_d; // Pin synchronisers and history
  logic [MBC_WDOG_CNT_W-1:0] unit_cnt, next_unit_cnt; // Cycles in step
  logic [6:0] step_cnt, next_step_cnt; // Elapsed 2 ms steps
  logic next_abort;
  logic next_out_en, next_oss, next_fwd_req;
  logic [6:0] next_fwd_addr;
  logic [7:0] next_rdata;
  logic scl_filt, sda_filt, scl_filt_d; // Filter outputs
  logic [3:0] hold_cnt, next_hold_cnt; // Cycles since SCL fell
  logic next_sda_clean;
  logic [3:0] hold_cycles; // Hold time in clock cycles
  logic [2:0] filt_cycles; // Filter width in clock cycles

  // Two flops on every pin: enable, sleep, mode12, mode10, scl, sda
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta <= 6'h03;
      sync <= 6'h03;
      sync_d <= 6'h03;
    end else begin
      meta <= {output_enable_pin, oss_pin, mode_pin_12hf, mode_pin_10,
        scl_pin, sda_pin};
      sync <= meta;
      sync_d <= sync;
    end
  end

  // Register writes and hardware mode updates
  always_comb begin
    next_mode_reg = mode_reg;
    next_wdog_to = wdog_to;
    next_wdog_dis = wdog_dis;
    next_i2c_reg = i2c_reg;
    if (reg_wr && reg_addr == MBC_MODE_OFS) begin
      next_mode_reg = reg_wdata & 8'hF3; // RQ5
    end else if (!mode_reg[MBC_OVR_MODE_BIT]) begin
      // Pin change reloads mode; forward channel wins if same cycle
      if (sync[3:2] != sync_d[3:2]) begin
        next_mode_reg[1:0] = sync[3:2]; // RQ6 RQ8
      end
      if (fwd_mode_valid) begin
        next_mode_reg[1:0] = {fwd_mode_12hf, fwd_mode_10}; // RQ4
      end
    end
    if (reg_wr && reg_addr == MBC_WDOG_OFS) begin
      next_wdog_to = reg_wdata[MBC_WDOG_TO_MSB:MBC_WDOG_TO_LSB];
      next_wdog_dis = reg_wdata[MBC_WDOG_DIS_BIT];
    end
    if (reg_wr && reg_addr == MBC_I2C_OFS) begin
      next_i2c_reg = reg_wdata;
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg <= MBC_MODE_RST;
      wdog_to <= MBC_WDOG_TO_RST;
      wdog_dis <= MBC_WDOG_DIS_RST;
      i2c_reg <= {MBC_PASS_ALL_RST, MBC_HOLD_RST, MBC_FILT_RST};
    end else begin
      mode_reg <= next_mode_reg;
      wdog_to <= next_wdog_to;
      wdog_dis <= next_wdog_dis;
      i2c_reg <= next_i2c_reg;
    end
  end

  // Effective output enable and sleep state selections, plus read mux
  always_comb begin
    if (mode_reg[MBC_OVR_OUT_BIT]) begin
      next_out_en = mode_reg[MBC_OUT_EN_BIT]; // RQ1 RQ2
      next_oss = mode_reg[MBC_OSS_BIT]; // RQ3
    end else begin
      next_out_en = sync[5]; // RQ1
      next_oss = sync[4];
    end
    case (reg_addr)
      MBC_MODE_OFS: next_rdata = {mode_reg[7:4], sync[3:2],
        mode_reg[1:0]}; // RQ5
      MBC_WDOG_OFS: next_rdata = {wdog_to, wdog_dis};
      MBC_I2C_OFS: next_rdata = i2c_reg;
      default: next_rdata = 8'h00; // Unmapped reads zero
    endcase
  end

  // Watchdog: count 2 ms steps while a transaction is open
  always_comb begin
    next_unit_cnt = '0;
    next_step_cnt = 7'h00;
    next_abort = 1'h0;
    if (ctrl_chan_busy && !wdog_dis && !ctrl_chan_abort) begin // RQ11
      if (unit_cnt == MBC_WDOG_CNT_W'(WDOG_UNIT_CYCLES - 1)) begin
        next_step_cnt = step_cnt + 7'h01;
        if (next_step_cnt == wdog_to && wdog_to != 7'h00) begin // RQ10
          next_abort = 1'h1; // RQ9
          next_step_cnt = 7'h00;
        end
      end else begin
        next_unit_cnt = unit_cnt + 1'b1;
        next_step_cnt = step_cnt;
      end
    end
  end

  // Pass-through decision on each incoming address
  always_comb begin
    next_fwd_req = 1'h0;
    next_fwd_addr = fwd_addr;
    if (i2c_addr_valid) begin
      if (i2c_reg[MBC_PASS_ALL_BIT]) begin
        if (i2c_addr != own_id) begin
          next_fwd_req = 1'h1; // RQ12
          next_fwd_addr = remote_serializer_target;
        end
      end else if (i2c_addr == remote_serializer_target ||
        i2c_addr == remote_alias_id) begin
        next_fwd_req = 1'h1; // RQ13
        next_fwd_addr = i2c_addr;
      end
    end
  end

  // Convert hold and filter fields to cycles, rounding up
  always_comb begin
    hold_cycles = 4'((32'(i2c_reg[MBC_HOLD_MSB:MBC_HOLD_LSB]) *
      MBC_HOLD_UNIT_NS + MBC_CLK_PERIOD_NS - 1) / MBC_CLK_PERIOD_NS); // RQ14
    filt_cycles = 3'((32'(i2c_reg[MBC_FILT_MSB:MBC_FILT_LSB]) *
      MBC_FILT_UNIT_NS + MBC_CLK_PERIOD_NS - 1) / MBC_CLK_PERIOD_NS); // RQ15
  end

  // Glitch filters on SCL and SDA
  mbc_glitch_filter u_scl_filt (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(sync[1]),
    .limit(filt_cycles), // RQ15
    .dout(scl_filt)
  );
  mbc_glitch_filter u_sda_filt (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(sync[0]),
    .limit(filt_cycles),
    .dout(sda_filt)
  );

  // SDA may change only once the hold time after SCL falling has passed
  always_comb begin
    next_hold_cnt = hold_cnt;
    if (scl_filt_d && !scl_filt) begin
      next_hold_cnt = 4'h0;
    end else if (hold_cnt != 4'hF) begin
      next_hold_cnt = hold_cnt + 4'h1;
    end
    next_sda_clean = sda_clean;
    // Block the update in the very cycle SCL falls, before hold_cnt restarts
    if (hold_cnt >= hold_cycles && !(scl_filt_d && !scl_filt)) begin
      next_sda_clean = sda_filt; // RQ14
    end
  end

  // Output and status registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      unit_cnt <= '0;
      step_cnt <= 7'h00;
      ctrl_chan_abort <= 1'h0;
      output_enable <= 1'h0;
      output_sleep_state <= 1'h0;
      mode_12hf <= 1'h0;
      mode_10 <= 1'h0;
      fwd_req <= 1'h0;
      fwd_addr <= 7'h00;
      reg_rdata <= 8'h00;
      scl_filt_d <= 1'h1;
      hold_cnt <= 4'hF;
      scl_clean <= 1'h1;
      sda_clean <= 1'h1;
    end else begin
      unit_cnt <= next_unit_cnt;
      step_cnt <= next_step_cnt;
      ctrl_chan_abort <= next_abort;
      output_enable <= next_out_en;
      output_sleep_state <= next_oss;
      mode_12hf <= mode_reg[MBC_MODE12_BIT]; // RQ7
      mode_10 <= mode_reg[MBC_MODE10_BIT];
      fwd_req <= next_fwd_req;
      fwd_addr <= next_fwd_addr;
      reg_rdata <= next_rdata;
      scl_filt_d <= scl_filt;
      hold_cnt <= next_hold_cnt;
      scl_clean <= scl_filt;
      sda_clean <= next_sda_clean;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  ovr_oen_a: assert property (mode_reg[7] |=> output_enable == // RQ2
    $past(mode_reg[6])) else $error("override enable wrong");
  ovr_oss_a: assert property (mode_reg[7] |=> output_sleep_state == // RQ3
    $past(mode_reg[5])) else $error("override sleep wrong");
  pin_oen_a: assert property (!mode_reg[7] |=> output_enable == // RQ1
    $past(sync[5])) else $error("pin enable wrong");
  mode_hold_a: assert property (mode_reg[4] && !(reg_wr && // RQ4
    reg_addr == 8'h1F) |=> $stable(mode_reg[1:0]))
    else $error("mode changed under override");
  fwd_mode_a: assert property (!mode_reg[4] && fwd_mode_valid && !reg_wr
    |=> mode_reg[1:0] == $past({fwd_mode_12hf, fwd_mode_10})) // RQ6
    else $error("forward mode missed");
  mode_out_a: assert property (1 |=> {mode_12hf, mode_10} == // RQ8
    $past(mode_reg[1:0])) else $error("mode output lag");
  pin_stat_a: assert property (reg_addr == 8'h1F |=> reg_rdata[3:2] == // RQ5
    $past(sync[3:2])) else $error("pin status wrong");
  wdog_off_a: assert property (wdog_dis |=> !ctrl_chan_abort) // RQ11
    else $error("abort while disabled");
  abort_step_a: assert property (ctrl_chan_abort |-> $past(step_cnt) + // RQ9
    7'h01 == $past(wdog_to)) else $error("abort at wrong step");
  pass_all_a: assert property (i2c_addr_valid && i2c_reg[7] && // RQ12
    i2c_addr != own_id |=> fwd_req && fwd_addr ==
    $past(remote_serializer_target)) else $error("pass-all missed");
  match_a: assert property (i2c_addr_valid && !i2c_reg[7] && // RQ13
    i2c_addr != remote_serializer_target && i2c_addr != remote_alias_id
    |=> !fwd_req) else $error("unmatched address forwarded");
  sda_hold_a: assert property (sda_clean != $past(sda_clean) |-> // RQ14
    !$fell(scl_clean) && $past(hold_cnt) >= $past(hold_cycles))
    else $error("hold too short");
  filt_lim_a: assert property (i2c_reg[3:0] == 4'h7 |-> // RQ15
    filt_cycles == 3'h2) else $error("filter cycles wrong");
  abort_c: cover property (ctrl_chan_abort);
  fwd_c: cover property (fwd_req && i2c_reg[7]);
  ovr_c: cover property (mode_reg[4] && mode_reg[1:0] == 2'h0);
endmodule

// >>> tb/mbc_far_end.sv
// Remote end model: opens control channel transactions, may stall them
`timescale 1ns/100ps
module mbc_far_end (
  input wire logic ref_clk, // 25 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic start, // Open a transaction
  input wire logic fwd_req, // A forwarded access opens one too
  input wire logic [7:0] span, // Cycles to finish, FF stalls
  input wire logic txn_abort, // Watchdog abort
  output logic txn_active // Transaction open
);
  logic [7:0] left; // Cycles still to run
  logic [7:0] next_left; // Next remaining count
  logic next_active; // Next open state
  // A stalled transaction only closes when the watchdog ends it
  always_comb begin
    next_left = left;
    next_active = txn_active;
    if (txn_abort) begin
      next_active = 1'b0;
    end else if (start || fwd_req) begin
      next_active = 1'b1;
      next_left = span;
    end else if (txn_active && span != 8'hFF) begin
      next_left = left - 8'h01;
      next_active = (left != 8'h01);
    end
  end
  // State registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      left <= 8'h00;
      txn_active <= 1'b0;
    end else begin
      left <= next_left;
      txn_active <= next_active;
    end
  end
endmodule

// >>> tb/mbc_config_regs_tb.sv
// Self-checking bench for the mode, watchdog and I2C configuration block
`timescale 1ns/100ps
module mbc_config_regs_tb;
  import mbc_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0; // Clock, reset, strobe
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd; // Bus
  logic en_pin = 1'b0, oss_pin = 1'b0, pin12 = 1'b0, pin10 = 1'b0; // Pins
  logic fv = 1'b0, f12 = 1'b0, f10 = 1'b0; // Forward mode update
  logic oe, oss, m12, m10, act, abort, start = 1'b0, freq; // Outputs
  logic [7:0] span = 8'h04; // Remote transaction length
  logic av = 1'b0, scl = 1'b1, sda = 1'b1, scl_c, sda_c; // I2C side
  logic [6:0] addr = 7'h00, faddr; // Incoming and forwarded address
  int err_count = 0, cmp_count = 0, n; // Counters
  mbc_config_regs #(.WDOG_UNIT_CYCLES(4)) u_dut (.ref_clk(ref_clk),
    .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .output_enable_pin(en_pin), .oss_pin(oss_pin),
    .mode_pin_12hf(pin12), .mode_pin_10(pin10), .fwd_mode_valid(fv),
    .fwd_mode_12hf(f12), .fwd_mode_10(f10), .output_enable(oe),
    .output_sleep_state(oss), .mode_12hf(m12), .mode_10(m10),
    .ctrl_chan_busy(act), .ctrl_chan_abort(abort), .i2c_addr_valid(av),
    .i2c_addr(addr), .own_id(7'h2C), .remote_serializer_target(7'h58),
    .remote_alias_id(7'h40), .fwd_req(freq), .fwd_addr(faddr),
    .scl_pin(scl), .sda_pin(sda), .scl_clean(scl_c), .sda_clean(sda_c));
  mbc_far_end u_far (.ref_clk(ref_clk), .rst(rst), .start(start),
    .fwd_req(freq), .span(span), .txn_abort(abort), .txn_active(act));
  // Clock at 25 MHz
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // Compare one value and count it
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Let k edges pass, then step off the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // Write one register byte
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read one register byte
  task automatic rdr(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    cyc(2);
    rd = reg_rdata;
  endtask
  // Reset values and the unmapped place
  task automatic t_reset();
    rdr(MBC_MODE_OFS); chk("mode", rd, 8'h00);
    rdr(MBC_WDOG_OFS); chk("wdog", rd, 8'hFE);
    rdr(MBC_I2C_OFS); chk("i2c", rd, 8'h17);
    rdr(8'h22); chk("unmapped", rd, 8'h00);
  endtask
  // Pins rule the outputs until the override bit is set
  task automatic t_out();
    @(posedge ref_clk);
    en_pin <= 1'b1;
    wr(MBC_MODE_OFS, 8'h60); cyc(6);
    chk("oe pin", {7'h00, oe}, 8'h01);
    chk("oss pin", {7'h00, oss}, 8'h00);
    wr(MBC_MODE_OFS, 8'hA0); cyc(3);
    chk("oe reg", {7'h00, oe}, 8'h00);
    chk("oss reg", {7'h00, oss}, 8'h01);
    oss_pin <= 1'b1;
    wr(MBC_MODE_OFS, 8'h00);
    cyc(3);
    chk("oss pin high", {7'h00, oss}, 8'h01);
  endtask
  // Mode from pins, override, read-only status, forward channel
  task automatic t_mode();
    pin12 <= 1'b1; cyc(6);
    rdr(MBC_MODE_OFS); chk("pin mode", rd, 8'h0A);
    chk("m12", {7'h00, m12}, 8'h01);
    wr(MBC_MODE_OFS, 8'h1C); cyc(3);
    rdr(MBC_MODE_OFS); chk("ro bits", rd, 8'h18);
    chk("lf mode", {6'h00, m12, m10}, 8'h00);
    @(posedge ref_clk); fv <= 1'b1; f10 <= 1'b1;
    @(posedge ref_clk); fv <= 1'b0;
    pin12 <= 1'b0; pin10 <= 1'b1; cyc(6);
    rdr(MBC_MODE_OFS); chk("held", rd, 8'h14);
    chk("held out", {6'h00, m12, m10}, 8'h00);
    wr(MBC_MODE_OFS, 8'h00);
    @(posedge ref_clk); fv <= 1'b1;
    @(posedge ref_clk); fv <= 1'b0; cyc(3);
    chk("fwd mode", {6'h00, m12, m10}, 8'h01);
  endtask
  // Stalled transaction is aborted; disabled watchdog never aborts
  task automatic t_wdog(input logic [7:0] v, input int exp);
    wr(MBC_WDOG_OFS, v);
    span <= 8'hFF;
    @(posedge ref_clk); start <= 1'b1;
    @(posedge ref_clk); start <= 1'b0;
    n = 0;
    while (act !== 1'b1 && n < 8) begin
      cyc(1); n++;
    end
    n = 0;
    while (abort !== 1'b1 && n < 60) begin
      cyc(1); n++;
    end
    chk("abort time", 8'(n), 8'(exp));
    if (abort !== 1'b1) begin
      @(posedge ref_clk);
      start <= 1'b1;
      wr(MBC_WDOG_OFS, 8'h02);
      start <= 1'b0;
      cyc(10);
    end
    span <= 8'h04;
  endtask
  // Forwarding policy with pass-all clear and set
  task automatic t_fwd(input logic [7:0] ctl, input logic [6:0] a,
                       input logic f, input logic [6:0] fa);
    wr(MBC_I2C_OFS, ctl);
    @(posedge ref_clk); av <= 1'b1; addr <= a;
    @(posedge ref_clk); av <= 1'b0; #1;
    chk("fwd req", {7'h00, freq}, {7'h00, f});
    if (f) chk("fwd addr", {1'b0, faddr}, {1'b0, fa});
    cyc(8);
  endtask
  // Short SCL glitch is dropped, a long low level passes
  task automatic t_filt();
    @(posedge ref_clk); scl <= 1'b0;
    @(posedge ref_clk); scl <= 1'b1; cyc(10);
    chk("glitch", {7'h00, scl_c}, 8'h01);
    @(posedge ref_clk);
    scl <= 1'b0;
    sda <= 1'b0;
    n = 0;
    while (scl_c !== 1'b0 && n < 20) begin
      cyc(1);
      n++;
    end
    chk("sda hold", {7'h00, sda_c}, 8'h01);
    cyc(12);
    chk("low", {7'h00, scl_c}, 8'h00);
    chk("sda late", {7'h00, sda_c}, 8'h00);
    @(posedge ref_clk);
    scl <= 1'b1;
    sda <= 1'b1;
    cyc(12);
    chk("sda idle", {7'h00, sda_c}, 8'h01);
  endtask
  // Report and end the run
  task automatic close_out();
    $display("Compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_out();
    t_mode();
    t_wdog(8'h02, 3);
    t_wdog(8'h04, 7);
    t_wdog(8'h03, 60);
    t_fwd(8'h17, 7'h40, 1'b1, 7'h40);
    t_fwd(8'h17, 7'h33, 1'b0, 7'h00);
    t_fwd(8'h97, 7'h33, 1'b1, 7'h58);
    t_fwd(8'h97, 7'h2C, 1'b0, 7'h00);
    t_filt();
    close_out();
  end
  // Watchdog against a hang
  initial begin
    #(40 * 20000);
    err_count++;
    close_out();
  end
endmodule
